// ==== i2cmm_top.sv ====
// Two-wire multi-master bus monitor with slave receiver and register slave
//
// Chosen here: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// R1 - Reset or disable clears start/stop bits
// R2 - Start/stop bits follow latest bus condition
// R3 - Firmware takes bus after stop or idle
// R4 - Stop raises interrupt when bus frees
// R5 - Compare data line while driving high
// R6 - High expected, low seen: release both lines
// R7 - Loss detected in address and data stage
// R8 - Slave keeps receiving after lost arbitration
// R9 - Own address matched: slave sends acknowledge; the code acknowledges only addresses whose read/write bit is 0
// R10 - Firmware repeats data after data-stage loss
// R11 - Firmware keeps status bits 7:6 clear
// R12 - Output direction always drives pin low
// R13 - Flag on start, stop, each byte while own master or addressed slave
// R14 - Loser stays off bus until stop
// R15 - Data compared while clock line high
module i2cmm_top
  import i2cmm_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // AXI4-Lite write address
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // AXI4-Lite write data
  input wire logic [DATA_W-1:0] s_axi_wdata,
  input wire logic [DATA_W/8-1:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read address
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // AXI4-Lite read data
  output logic [DATA_W-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Two-wire bus clock line
  input wire logic scl_in,
  output logic scl_out,
  output logic scl_oe,
  // Two-wire bus data line
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  // Interrupt
  output logic irq
);

  // ==========================================================================
  // Register state
  logic [REG_W-1:0] gic_r;
  logic [REG_W-1:0] flags_r;
  logic [REG_W-1:0] enables_r;
  logic [REG_W-1:0] buffer_r;
  logic [REG_W-1:0] ctrl_r;
  logic [REG_W-1:0] dir_r;
  logic [REG_W-1:0] own_addr_r;
  logic [1:0] sw_stat_r;
  logic start_seen_r;
  logic stop_seen_r;
  logic data_addr_r;
  logic read_write_r;
  logic buf_full_r;
  logic [1:0] arb_r;

  // ==========================================================================
  // Bus slave state
  logic awready_r;
  logic wready_r;
  logic bvalid_r;
  logic [1:0] bresp_r;
  logic arready_r;
  logic rvalid_r;
  logic [1:0] rresp_r;
  logic [DATA_W-1:0] rdata_r;
  logic aw_got_r;
  logic w_got_r;
  logic [IDX_W-1:0] wr_idx_r;
  logic [REG_W-1:0] wr_data_r;
  logic wr_lane_r;

  // ==========================================================================
  // Line sampling and protocol state
  logic scl_meta_r;
  logic scl_sync_r;
  logic scl_prev_r;
  logic sda_meta_r;
  logic sda_sync_r;
  logic sda_prev_r;
  i2cmm_stage_t stage_r;
  logic [3:0] bitcnt_r;
  logic [REG_W-1:0] shift_r;
  logic addressed_r;
  logic ack_r;
  logic master_own_r;
  logic scl_oe_r;
  logic sda_oe_r;
  logic irq_r;

  // ==========================================================================
  // Decoded events
  logic module_en;
  logic slave_en;
  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;
  logic byte_end;
  logic byte_take;
  logic addr_match;
  logic arb_lost;
  logic wr_fire;
  logic rd_fire;
  logic [IDX_W-1:0] rd_idx;
  logic [REG_W-1:0] rd_val;
  logic rd_hit;
  logic wr_hit;

  assign module_en = ctrl_r[CTRL_MODULE_EN];
  assign slave_en = module_en && (ctrl_r[CTRL_MODE_HI:CTRL_MODE_LO] == MODE_SLAVE7 ||
                                  ctrl_r[CTRL_MODE_HI:CTRL_MODE_LO] == MODE_SLAVE7_IRQ);
  assign scl_rise = scl_sync_r && !scl_prev_r;
  assign scl_fall = !scl_sync_r && scl_prev_r;
  assign start_det = module_en && scl_sync_r && scl_prev_r && !sda_sync_r && sda_prev_r;
  assign stop_det = module_en && scl_sync_r && scl_prev_r && sda_sync_r && !sda_prev_r;
  assign byte_end = scl_fall && stage_r != I2CMM_IDLE && bitcnt_r == BIT_ACK;
  assign byte_take = scl_fall && stage_r != I2CMM_IDLE && bitcnt_r == BIT_LAST_DATA;
  assign addr_match = shift_r[REG_W-1:1] == own_addr_r[REG_W-1:1];
  // Only bits in which a high level is released are checked, never the acknowledge slot
  assign arb_lost = master_own_r && scl_rise && dir_r[DIR_SDA] && !sda_sync_r && // R5 R15
                    stage_r != I2CMM_IDLE && bitcnt_r != BIT_ACK;
  assign wr_fire = aw_got_r && w_got_r && !bvalid_r;
  assign rd_fire = s_axi_arvalid && arready_r;
  assign rd_idx = s_axi_araddr[ADDR_W-1:2];

  // ==========================================================================
  // Synchronisers and edge history
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      scl_meta_r <= 1'b1;
      scl_sync_r <= 1'b1;
      scl_prev_r <= 1'b1;
      sda_meta_r <= 1'b1;
      sda_sync_r <= 1'b1;
      sda_prev_r <= 1'b1;
    end else begin
      scl_meta_r <= scl_in;
      scl_sync_r <= scl_meta_r;
      scl_prev_r <= scl_sync_r;
      sda_meta_r <= sda_in;
      sda_sync_r <= sda_meta_r;
      sda_prev_r <= sda_sync_r;
    end
  end

  // ==========================================================================
  // Transfer stage and bit counting, shared by master and slave
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      stage_r <= I2CMM_IDLE;
      bitcnt_r <= 4'h0;
      shift_r <= RST_ZERO;
    end else if (!module_en || stop_det) begin
      stage_r <= I2CMM_IDLE;
      bitcnt_r <= 4'h0;
    end else if (start_det) begin
      // The start's own clock fall wraps the count to zero before the first bit
      stage_r <= I2CMM_ADDRESS;
      bitcnt_r <= '1;
    end else begin
      if (scl_rise && bitcnt_r != BIT_ACK) begin
        shift_r <= {shift_r[REG_W-2:0], sda_sync_r};
      end
      if (byte_end) begin
        bitcnt_r <= 4'h0;
        stage_r <= I2CMM_DATA; // R7
      end else if (scl_fall && stage_r != I2CMM_IDLE) begin
        bitcnt_r <= bitcnt_r + 4'h1;
      end
    end
  end

  // ==========================================================================
  // Slave receiver: address compare and acknowledge
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      addressed_r <= 1'b0;
      ack_r <= 1'b0;
    end else if (!module_en || start_det || stop_det) begin
      addressed_r <= 1'b0;
      ack_r <= 1'b0;
    end else if (byte_take && slave_en) begin
      // Slave logic keeps listening even after this end lost the bus
      if (stage_r == I2CMM_ADDRESS && addr_match && !shift_r[0]) begin // R8
        addressed_r <= 1'b1;
        ack_r <= 1'b1; // R9
      end else if (stage_r == I2CMM_DATA && addressed_r) begin
        ack_r <= 1'b1;
      end
    end else if (byte_end) begin
      ack_r <= 1'b0;
    end
  end

  // ==========================================================================
  // Master ownership and arbitration
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      master_own_r <= 1'b0;
    end else if (!module_en || stop_det || arb_lost) begin
      master_own_r <= 1'b0;
    end else if (start_det && !dir_r[DIR_SDA]) begin
      master_own_r <= 1'b1;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      arb_r <= 2'h0;
    end else begin
      if (arb_lost && stage_r == I2CMM_ADDRESS) begin
        arb_r[ARB_LOST_ADDR] <= 1'b1; // R7
      end else if (wr_fire && wr_lane_r && wr_idx_r == IDX_ARB_STATUS && wr_data_r[ARB_LOST_ADDR]) begin
        arb_r[ARB_LOST_ADDR] <= 1'b0;
      end
      if (arb_lost && stage_r == I2CMM_DATA) begin
        arb_r[ARB_LOST_DATA] <= 1'b1; // R7
      end else if (wr_fire && wr_lane_r && wr_idx_r == IDX_ARB_STATUS && wr_data_r[ARB_LOST_DATA]) begin
        arb_r[ARB_LOST_DATA] <= 1'b0;
      end
    end
  end

  // ==========================================================================
  // Direction register: software writes, arbitration loss releases both lines
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      dir_r <= RST_PORT_C_DIR;
    end else if (arb_lost) begin
      dir_r[DIR_SDA] <= 1'b1; // R6
      dir_r[DIR_SCL] <= 1'b1; // R6
    end else if (wr_fire && wr_lane_r && wr_idx_r == IDX_PORT_C_DIR) begin
      dir_r <= wr_data_r;
    end
  end

  // ==========================================================================
  // Pin drivers: an output direction always pulls low
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      scl_oe_r <= 1'b0;
      sda_oe_r <= 1'b0;
    end else begin
      scl_oe_r <= !dir_r[DIR_SCL] && !arb_lost; // R12
      sda_oe_r <= (!dir_r[DIR_SDA] && !arb_lost) || ack_r; // R12
    end
  end

  // ==========================================================================
  // Status bits
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      start_seen_r <= 1'b0;
      stop_seen_r <= 1'b0;
    end else if (!module_en) begin
      start_seen_r <= 1'b0; // R1
      stop_seen_r <= 1'b0; // R1
    end else if (start_det) begin
      start_seen_r <= 1'b1; // R2
      stop_seen_r <= 1'b0; // R2
    end else if (stop_det) begin
      start_seen_r <= 1'b0; // R2
      stop_seen_r <= 1'b1; // R2
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      buffer_r <= RST_ZERO;
      buf_full_r <= 1'b0;
      data_addr_r <= 1'b0;
      read_write_r <= 1'b0;
    end else if (byte_take && (master_own_r || (slave_en && (addressed_r ||
                 (stage_r == I2CMM_ADDRESS && addr_match))))) begin
      buffer_r <= shift_r;
      buf_full_r <= 1'b1;
      data_addr_r <= stage_r == I2CMM_DATA;
      if (stage_r == I2CMM_ADDRESS) begin
        read_write_r <= shift_r[0];
      end
    end else if (wr_fire && wr_lane_r && wr_idx_r == IDX_SERIAL_BUFFER) begin
      buffer_r <= wr_data_r;
    end else if (rd_fire && rd_idx == IDX_SERIAL_BUFFER) begin
      buf_full_r <= 1'b0;
    end
  end

  // ==========================================================================
  // Interrupt flag: hardware set wins over the write-one clear
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      flags_r <= RST_ZERO;
    end else if (start_det || stop_det || (byte_end && (master_own_r || addressed_r))) begin
      flags_r[FLAG_SERIAL] <= 1'b1; // R4 R13
    end else if (wr_fire && wr_lane_r && wr_idx_r == IDX_IRQ_FLAGS && wr_data_r[FLAG_SERIAL]) begin
      flags_r[FLAG_SERIAL] <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= gic_r[GIC_GLOBAL_EN] && gic_r[GIC_PERIPH_EN] && |(flags_r & enables_r); // R4
    end
  end

  // ==========================================================================
  // Plain software registers
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      gic_r <= RST_ZERO;
      enables_r <= RST_ZERO;
      ctrl_r <= RST_ZERO;
      own_addr_r <= RST_ZERO;
      sw_stat_r <= 2'h0;
    end else if (wr_fire && wr_lane_r) begin
      case (wr_idx_r)
        IDX_GLOBAL_IRQ_CTRL: gic_r <= wr_data_r;
        IDX_IRQ_ENABLES: enables_r <= wr_data_r;
        IDX_SERIAL_CTRL: ctrl_r <= wr_data_r;
        IDX_OWN_ADDR: own_addr_r <= wr_data_r;
        IDX_SERIAL_STATUS: sw_stat_r <= wr_data_r[STAT_SAMPLE_PHASE:STAT_CLOCK_EDGE];
        default: ;
      endcase
    end
  end

  // ==========================================================================
  // AXI4-Lite write path
  always_comb begin
    case (wr_idx_r)
      IDX_GLOBAL_IRQ_CTRL, IDX_IRQ_FLAGS, IDX_SERIAL_BUFFER, IDX_SERIAL_CTRL,
      IDX_PORT_C_DIR, IDX_IRQ_ENABLES, IDX_OWN_ADDR, IDX_SERIAL_STATUS,
      IDX_ARB_STATUS: wr_hit = 1'b1;
      default: wr_hit = 1'b0;
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      awready_r <= 1'b1;
      wready_r <= 1'b1;
      aw_got_r <= 1'b0;
      w_got_r <= 1'b0;
      bvalid_r <= 1'b0;
      bresp_r <= RESP_OKAY;
      wr_idx_r <= RST_ZERO;
      wr_data_r <= RST_ZERO;
      wr_lane_r <= 1'b0;
    end else begin
      if (s_axi_awvalid && awready_r) begin
        wr_idx_r <= s_axi_awaddr[ADDR_W-1:2];
        aw_got_r <= 1'b1;
        awready_r <= 1'b0;
      end
      if (s_axi_wvalid && wready_r) begin
        wr_data_r <= s_axi_wdata[REG_W-1:0];
        wr_lane_r <= s_axi_wstrb[0];
        w_got_r <= 1'b1;
        wready_r <= 1'b0;
      end
      if (wr_fire) begin
        bvalid_r <= 1'b1;
        bresp_r <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end
      if (bvalid_r && s_axi_bready) begin
        bvalid_r <= 1'b0;
        aw_got_r <= 1'b0;
        w_got_r <= 1'b0;
        awready_r <= 1'b1;
        wready_r <= 1'b1;
      end
    end
  end

  // ==========================================================================
  // AXI4-Lite read path
  always_comb begin
    rd_hit = 1'b1;
    case (rd_idx)
      IDX_GLOBAL_IRQ_CTRL: rd_val = gic_r;
      IDX_IRQ_FLAGS: rd_val = flags_r;
      IDX_SERIAL_BUFFER: rd_val = buffer_r;
      IDX_SERIAL_CTRL: rd_val = ctrl_r;
      IDX_PORT_C_DIR: rd_val = dir_r;
      IDX_IRQ_ENABLES: rd_val = enables_r;
      IDX_OWN_ADDR: rd_val = own_addr_r;
      IDX_SERIAL_STATUS: rd_val = {sw_stat_r, data_addr_r, stop_seen_r, start_seen_r,
                                   read_write_r, 1'b0, buf_full_r};
      IDX_ARB_STATUS: rd_val = {6'h00, arb_r};
      default: begin
        rd_val = RST_ZERO;
        rd_hit = 1'b0;
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      arready_r <= 1'b1;
      rvalid_r <= 1'b0;
      rresp_r <= RESP_OKAY;
      rdata_r <= '0;
    end else if (rd_fire) begin
      arready_r <= 1'b0;
      rvalid_r <= 1'b1;
      rresp_r <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      rdata_r <= {{(DATA_W-REG_W){1'b0}}, rd_val};
    end else if (rvalid_r && s_axi_rready) begin
      rvalid_r <= 1'b0;
      arready_r <= 1'b1;
    end
  end

  // ==========================================================================
  // Outputs
  assign s_axi_awready = awready_r;
  assign s_axi_wready = wready_r;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;
  assign s_axi_arready = arready_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rresp = rresp_r;
  assign s_axi_rdata = rdata_r;
  assign scl_out = 1'b0;
  assign sda_out = 1'b0;
  assign scl_oe = scl_oe_r;
  assign sda_oe = sda_oe_r;
  assign irq = irq_r;

endmodule
`default_nettype wire

// ==== i2cmm_pkg.sv ====
// Constants, register map and types of the two-wire multi-master monitor
package i2cmm_pkg;

  // ==========================================================================
  // Bus geometry
  localparam int ADDR_W = 10;
  localparam int DATA_W = 32;
  localparam int IDX_W = 8;
  localparam int REG_W = 8;

  // ==========================================================================
  // Register indices (byte address is four times the index)
  localparam logic [IDX_W-1:0] IDX_GLOBAL_IRQ_CTRL = 8'h0b;
  localparam logic [IDX_W-1:0] IDX_IRQ_FLAGS = 8'h0c;
  localparam logic [IDX_W-1:0] IDX_SERIAL_BUFFER = 8'h13;
  localparam logic [IDX_W-1:0] IDX_SERIAL_CTRL = 8'h14;
  localparam logic [IDX_W-1:0] IDX_PORT_C_DIR = 8'h87;
  localparam logic [IDX_W-1:0] IDX_IRQ_ENABLES = 8'h8c;
  localparam logic [IDX_W-1:0] IDX_OWN_ADDR = 8'h93;
  localparam logic [IDX_W-1:0] IDX_SERIAL_STATUS = 8'h94;
  localparam logic [IDX_W-1:0] IDX_ARB_STATUS = 8'h95;

  // ==========================================================================
  // Reset values
  localparam logic [REG_W-1:0] RST_ZERO = 8'h00;
  localparam logic [REG_W-1:0] RST_PORT_C_DIR = 8'hff;

  // ==========================================================================
  // Field positions
  localparam int GIC_GLOBAL_EN = 7;
  localparam int GIC_PERIPH_EN = 6;
  localparam int FLAG_SERIAL = 3;
  localparam int CTRL_MODULE_EN = 5;
  localparam int CTRL_MODE_HI = 3;
  localparam int CTRL_MODE_LO = 0;
  localparam int DIR_SCL = 3;
  localparam int DIR_SDA = 4;
  localparam int STAT_SAMPLE_PHASE = 7;
  localparam int STAT_CLOCK_EDGE = 6;
  localparam int STAT_DATA_ADDR = 5;
  localparam int STAT_STOP = 4;
  localparam int STAT_START = 3;
  localparam int STAT_READ_WRITE = 2;
  localparam int STAT_UPDATE_ADDR = 1;
  localparam int STAT_BUF_FULL = 0;
  localparam int ARB_LOST_ADDR = 0;
  localparam int ARB_LOST_DATA = 1;

  // ==========================================================================
  // Mode codes and bit counting
  localparam logic [3:0] MODE_SLAVE7 = 4'h6;
  localparam logic [3:0] MODE_SLAVE7_IRQ = 4'he;
  localparam logic [3:0] BIT_LAST_DATA = 4'h7;
  localparam logic [3:0] BIT_ACK = 4'h8;

  // ==========================================================================
  // Bus responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    I2CMM_IDLE,
    I2CMM_ADDRESS,
    I2CMM_DATA
  } i2cmm_stage_t;

endpackage

// ==== i2cmm_checker.sv ====
// Port-level assertions for the two-wire multi-master monitor
`timescale 1ns/1ps
`default_nettype none
module i2cmm_checker
  import i2cmm_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Register bus
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic [DATA_W-1:0] s_axi_wdata,
  input wire logic [DATA_W/8-1:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [DATA_W-1:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Bus lines and interrupt
  input wire logic scl_in,
  input wire logic scl_out,
  input wire logic scl_oe,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe,
  input wire logic irq
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  // ==========================================
  // Sequences
  sequence s_wr_take;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_dir_wr;
    s_wr_take ##0 (s_axi_awaddr == {IDX_PORT_C_DIR, 2'b00}) && s_axi_wstrb[0];
  endsequence
  sequence s_lost_bit;
    $rose(scl_in) && !sda_in && !sda_oe;
  endsequence
  // ==========================================
  // Properties
  property p_reset_quiet;
    $rose(rst_n) |-> !irq && !scl_oe && !sda_oe;
  endproperty
  a_reset_quiet: assert property (p_reset_quiet) else $error("outputs active after reset");
  property p_pins_low;
    !scl_out && !sda_out;
  endproperty
  a_pins_low: assert property (p_pins_low) else $error("pin drives a high level");
  property p_scl_follow;
    s_dir_wr |-> ##3 (scl_oe == !$past(s_axi_wdata[DIR_SCL], 3));
  endproperty
  a_scl_follow: assert property (p_scl_follow) else $error("clock enable ignores direction");
  property p_lost_release;
    s_lost_bit |-> (!scl_oe && !sda_oe) [*4];
  endproperty
  a_lost_release: assert property (p_lost_release) else $error("line driven after low seen");
  property p_wr_answer;
    s_wr_take |=> !s_axi_awready ##1 (s_axi_bvalid && !s_axi_awready);
  endproperty
  a_wr_answer: assert property (p_wr_answer) else $error("write not answered");
  property p_rd_answer;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && (s_axi_rdata[31:8] == 24'h00_0000);
  endproperty
  a_rd_answer: assert property (p_rd_answer) else $error("read not answered");
  property p_b_hold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_b_hold: assert property (p_b_hold) else $error("write response dropped");
  property p_r_hold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_r_hold: assert property (p_r_hold) else $error("read data dropped");
endmodule
bind i2cmm_top i2cmm_checker chk_u (.*);
`default_nettype wire

// ==== i2cmm_bus_model.sv ====
// Other master on the shared two-wire bus
`timescale 1ns/1ps
`default_nettype none
module i2cmm_bus_model (
  // Clock and wire levels
  input wire logic clk,
  input wire logic scl,
  input wire logic sda,
  // Pull-down enables
  output logic scl_oe_m,
  output logic sda_oe_m
);
  initial begin
    scl_oe_m = 1'b0;
    sda_oe_m = 1'b0;
  end
  // Half of a 125 ns link period, alternating 12 and 13 cycles
  bit half_odd = 1'b0;
  task automatic hp();
    repeat (half_odd ? 13 : 12) @(posedge clk);
    half_odd = !half_odd;
  endtask
  task automatic hold_sda(input logic lo);
    sda_oe_m <= lo;
  endtask
  task automatic start_c();
    sda_oe_m <= 1'b1;
    hp();
    scl_oe_m <= 1'b1;
    hp();
  endtask
  task automatic stop_c();
    sda_oe_m <= 1'b1;
    hp();
    scl_oe_m <= 1'b0;
    hp();
    sda_oe_m <= 1'b0;
    hp();
  endtask
  task automatic bit_tx(input logic b, output logic sample_phase_select);
    sda_oe_m <= !b;
    hp();
    scl_oe_m <= 1'b0;
    hp();
    sample_phase_select = sda;
    scl_oe_m <= 1'b1;
  endtask
  // Eight bits MSB first, then releases the line for the acknowledge
  task automatic byte_tx(input logic [7:0] d, output logic ak);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_tx(d[i], s);
    end
    bit_tx(1'b1, ak);
  endtask
endmodule
`default_nettype wire

// ==== i2c_multimaster_bus_monitor_test.sv ====
// Self-checking bench of the two-wire multi-master monitor
`timescale 1ns/1ps
`default_nettype none
module i2c_multimaster_bus_monitor_test;
  import i2cmm_pkg::*;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [ADDR_W-1:0] awaddr = '0, araddr = '0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [DATA_W-1:0] wdata = '0;
  logic [3:0] wstrb = 4'hf;
  logic awready, wready, bvalid, arready, rvalid, irq, scl_out, sda_out, scl_oe, sda_oe, scl_oe_m, sda_oe_m;
  logic [1:0] bresp, rresp;
  logic [DATA_W-1:0] rdata;
  wire logic scl_w = !(scl_oe || scl_oe_m);
  wire logic sda_w = !(sda_oe || sda_oe_m);
  int err_total = 0;
  int tests_run = 0;
  logic [7:0] own, dat, rd;
  logic ak;
  always #2.5 sys_clk = !sys_clk;
  i2cmm_top dut_u (.sys_clk(sys_clk), .rst_n(rst_n), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .scl_in(scl_w), .scl_out(scl_out),
    .scl_oe(scl_oe), .sda_in(sda_w), .sda_out(sda_out), .sda_oe(sda_oe), .irq(irq));
  i2cmm_bus_model model_u (.clk(sys_clk), .scl(scl_w), .sda(sda_w), .scl_oe_m(scl_oe_m), .sda_oe_m(sda_oe_m));
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic axi_wr(input logic [7:0] idx, input logic [7:0] d, input logic [1:0] er);
    logic ad, wd, a, w, b;
    logic [1:0] r;
    ad = 0;
    wd = 0;
    @(posedge sys_clk);
    awaddr <= {idx, 2'b00};
    wdata <= {24'h00_0000, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(ad && wd)) begin
      @(negedge sys_clk);
      a = awready && awvalid;
      w = wready && wvalid;
      @(posedge sys_clk);
      if (a) begin ad = 1; awvalid <= 1'b0; end
      if (w) begin wd = 1; wvalid <= 1'b0; end
    end
    do begin
      @(negedge sys_clk);
      b = bvalid;
      r = bresp;
      @(posedge sys_clk);
    end while (!b);
    bready <= 1'b0;
    chk("bresp", {30'h0, r}, {30'h0, er});
  endtask
  task automatic axi_rd(input logic [7:0] idx, output logic [7:0] d, input logic [1:0] er);
    logic a, v;
    logic [31:0] q;
    logic [1:0] r;
    @(posedge sys_clk);
    araddr <= {idx, 2'b00};
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(negedge sys_clk);
      a = arready;
      @(posedge sys_clk);
    end while (!a);
    arvalid <= 1'b0;
    do begin
      @(negedge sys_clk);
      v = rvalid;
      q = rdata;
      r = rresp;
      @(posedge sys_clk);
    end while (!v);
    rready <= 1'b0;
    d = q[7:0];
    chk("rresp", {30'h0, r}, {30'h0, er});
  endtask
  task automatic rd_chk(input string nm, input logic [7:0] idx, input logic [7:0] mask, input logic [7:0] e);
    logic [7:0] v;
    axi_rd(idx, v, RESP_OKAY);
    chk(nm, {24'h0, v & mask}, {24'h0, e});
  endtask
  task automatic irq_chk(input logic e);
    @(negedge sys_clk);
    chk("irq", {31'h0, irq}, {31'h0, e});
  endtask
  // One frame from the far master: address, then a data byte if acknowledged
  task automatic frame(input logic [7:0] a, input logic [7:0] d, input logic ack_exp);
    axi_wr(IDX_IRQ_FLAGS, 8'h08, RESP_OKAY);
    model_u.start_c();
    rd_chk("status", IDX_SERIAL_STATUS, 8'h18, 8'h08);
    rd_chk("flags", IDX_IRQ_FLAGS, 8'h08, 8'h08);
    axi_wr(IDX_IRQ_FLAGS, 8'h08, RESP_OKAY);
    model_u.byte_tx(a, ak);
    chk("addr_ack", {31'h0, ak}, {31'h0, ack_exp});
    if (!ack_exp) begin
      model_u.byte_tx(d, ak);
      chk("data_ack", {31'h0, ak}, 32'h0);
      rd_chk("buffer", IDX_SERIAL_BUFFER, 8'hff, d);
    end
    axi_wr(IDX_IRQ_FLAGS, 8'h08, RESP_OKAY);
    irq_chk(1'b0);
    model_u.stop_c();
    rd_chk("status", IDX_SERIAL_STATUS, 8'h18, 8'h10);
    irq_chk(1'b1);
  endtask
  initial begin
    #200us;
    err_total++;
    end_of_test();
  end
  initial begin
    logic [7:0] ri[6] = '{IDX_IRQ_FLAGS, IDX_SERIAL_CTRL, IDX_PORT_C_DIR, IDX_IRQ_ENABLES, IDX_OWN_ADDR,
      IDX_SERIAL_STATUS};
    logic [7:0] rv[6] = '{RST_ZERO, RST_ZERO, RST_PORT_C_DIR, RST_ZERO, RST_ZERO, RST_ZERO};
    void'($urandom(32'h6a665525));
    repeat (6) @(posedge sys_clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 6; i++) rd_chk("reset", ri[i], 8'hff, rv[i]);
    axi_rd(8'h50, rd, RESP_SLVERR);
    chk("unmapped", {24'h0, rd}, 32'h0);
    own = 8'($urandom) & 8'hfe;
    dat = 8'($urandom);
    axi_wr(IDX_OWN_ADDR, own, RESP_OKAY);
    axi_wr(IDX_SERIAL_CTRL, 8'h20 | {4'h0, MODE_SLAVE7}, RESP_OKAY);
    axi_wr(IDX_GLOBAL_IRQ_CTRL, 8'hc0, RESP_OKAY);
    axi_wr(IDX_IRQ_ENABLES, 8'h08, RESP_OKAY);
    axi_wr(IDX_SERIAL_STATUS, 8'h00, RESP_OKAY);
    rd_chk("mode_bits", IDX_SERIAL_STATUS, 8'hc0, 8'h00);
    frame(own ^ 8'h02, dat, 1'b1);
    axi_wr(IDX_SERIAL_CTRL, 8'h20 | {4'h0, MODE_SLAVE7_IRQ}, RESP_OKAY);
    frame(own, dat, 1'b0);
    // Own master starts, then loses a high bit to the far master
    rd_chk("bus_free", IDX_SERIAL_STATUS, 8'h18, 8'h10);
    axi_wr(IDX_PORT_C_DIR, 8'hef, RESP_OKAY);
    model_u.hp();
    rd_chk("status", IDX_SERIAL_STATUS, 8'h18, 8'h08);
    axi_wr(IDX_PORT_C_DIR, 8'he7, RESP_OKAY);
    model_u.hold_sda(1'b1);
    axi_wr(IDX_PORT_C_DIR, 8'hf7, RESP_OKAY);
    axi_wr(IDX_PORT_C_DIR, 8'hff, RESP_OKAY);
    model_u.hp();
    rd_chk("arb", IDX_ARB_STATUS, 8'h03, 8'h01);
    rd_chk("dir", IDX_PORT_C_DIR, 8'h18, 8'h18);
    axi_wr(IDX_IRQ_FLAGS, 8'h08, RESP_OKAY);
    model_u.hold_sda(1'b0);
    model_u.hp();
    rd_chk("status", IDX_SERIAL_STATUS, 8'h18, 8'h10);
    irq_chk(1'b1);
    axi_wr(IDX_ARB_STATUS, 8'h03, RESP_OKAY);
    rd_chk("arb", IDX_ARB_STATUS, 8'h03, 8'h00);
    axi_wr(IDX_IRQ_ENABLES, 8'h00, RESP_OKAY);
    irq_chk(1'b0);
    axi_wr(IDX_SERIAL_CTRL, 8'h00, RESP_OKAY);
    rd_chk("status", IDX_SERIAL_STATUS, 8'h18, 8'h00);
    end_of_test();
  end
endmodule
`default_nettype wire
